// [rtl/rsfs_pkg.sv]
// constants and types for the regulator start-up and fault sequencer
`default_nettype none
package rsfs_pkg;
    // start delay after all start conditions hold
    localparam int START_DELAY = 384;
    localparam int DLY_W = 9;
    // consecutive faulty samples before power-good drops
    localparam int PG_FILT = 3;
    localparam int FLT_W = 2;
    // gate response to supply loss
    localparam int CLK_NS = 10;
    localparam int GATE_OFF_NS = 100;
    localparam int GATE_OFF_CYC = (GATE_OFF_NS / CLK_NS < 1) ? 1 : GATE_OFF_NS / CLK_NS;
    // share bus limit
    localparam int MAX_PHASES = 6;
    localparam int PH_W = 3;
    // register byte offsets
    localparam logic [3:0] A_CTRL = 4'h0;
    localparam logic [3:0] A_STATUS = 4'h4;
    localparam logic [3:0] A_SSCNT = 4'h8;
    localparam logic [3:0] A_PHASES = 4'hc;
    // register fields and reset values
    localparam int CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RST = 1'h1;
    localparam logic [PH_W-1:0] PHASES_RST = 3'h1;
    // bus responses
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // synchronised flag positions
    localparam int F_VCC = 0;
    localparam int F_GDS = 1;
    localparam int F_EN = 2;
    localparam int F_LOCK = 3;
    localparam int F_OV120 = 4;
    localparam int F_OV113 = 5;
    localparam int F_B87 = 6;
    localparam int F_ABOVE = 7;
    localparam int F_PGWIN = 8;
    localparam int F_UV = 9;
    localparam int F_OC = 10;
    localparam int F_HOT = 11;
    localparam int F_COOL = 12;
    localparam int F_MOD = 13;
    localparam int F_PWM = 14;
    localparam int F_PH = 15;
    localparam int NF = 16;
    // sequencer states
    typedef enum logic [2:0] {
        ST_OFF = 3'h0,
        ST_WAIT = 3'h1,
        ST_SOFT = 3'h2,
        ST_RUN = 3'h3,
        ST_LATCH = 3'h4
    } rsfs_state_t;
endpackage
`default_nettype wire

// [rtl/rsfs_sequencer.sv]
// start-up, power-good and fault sequencer with axi4-lite registers
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`default_nettype none
module rsfs_sequencer #(
    parameter int SS_W = 10,
    parameter int SS_TOP = 1023
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // comparator flags
    input wire logic vcc_por_ok,
    input wire logic gate_drive_supply_por_ok,
    input wire logic en_pin_level,
    input wire logic pll_locked,
    input wire logic ov_latch_trip,
    input wire logic ov_trip,
    input wire logic below_release,
    input wire logic above_target,
    input wire logic pg_window_ok,
    input wire logic uv_trip,
    input wire logic oc_fault,
    input wire logic ot_hot,
    input wire logic ot_cool,
    input wire logic modulator_pulse,
    input wire logic pwm_in,
    input wire logic phase_pulse,
    // shared open-drain enable line
    output logic en_o,
    output logic en_oe_n,
    output logic en_sink_on,
    // power stage and status
    output logic high_side_gate_drive,
    output logic low_side_gate_drive,
    output logic power_good_output,
    output logic [SS_W-1:0] soft_start_ref
);
    localparam int GOFF = rsfs_pkg::GATE_OFF_CYC;

    logic [rsfs_pkg::NF-1:0] raw;
    logic [rsfs_pkg::NF-1:0] s1_reg;
    logic [rsfs_pkg::NF-1:0] s2_reg;
    rsfs_pkg::rsfs_state_t st_reg;
    logic [rsfs_pkg::DLY_W-1:0] dly_reg;
    logic [SS_W-1:0] ss_reg;
    logic [rsfs_pkg::FLT_W-1:0] flt_reg;
    logic [rsfs_pkg::PH_W-1:0] phases_reg;
    logic sw_en_reg;
    logic armed_reg;
    logic boot_reg;
    logic ovl_ls_reg;
    logic nl_ls_reg;
    logic pre_hold_reg;
    logic ot_reg;
    logic aw_got_reg;
    logic w_got_reg;
    logic [3:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic por_ok;
    logic ready;
    logic run_st;
    logic ss_done;
    logic en_pull;
    logic pg_fault;
    logic drive_ok;

    function automatic logic known(input logic [3:0] a);
        return a == rsfs_pkg::A_CTRL || a == rsfs_pkg::A_STATUS
            || a == rsfs_pkg::A_SSCNT || a == rsfs_pkg::A_PHASES;
    endfunction

    // flag synchroniser
    assign raw = {phase_pulse, pwm_in, modulator_pulse, ot_cool, ot_hot,
                  oc_fault, uv_trip, pg_window_ok, above_target,
                  below_release, ov_trip, ov_latch_trip, pll_locked,
                  en_pin_level, gate_drive_supply_por_ok, vcc_por_ok};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_reg <= '0;
            s2_reg <= '0;
        end else begin
            s1_reg <= raw;
            s2_reg <= s1_reg;
        end
    end

    assign por_ok = s2_reg[rsfs_pkg::F_VCC] & s2_reg[rsfs_pkg::F_GDS];
    assign ready = por_ok & s2_reg[rsfs_pkg::F_EN]
                 & s2_reg[rsfs_pkg::F_LOCK] & sw_en_reg;
    assign run_st = st_reg == rsfs_pkg::ST_SOFT || st_reg == rsfs_pkg::ST_RUN;
    assign ss_done = ss_reg == SS_W'(SS_TOP);
    assign en_pull = st_reg == rsfs_pkg::ST_LATCH | ot_reg | pre_hold_reg
                   | s2_reg[rsfs_pkg::F_OC];
    assign drive_ok = run_st & armed_reg & ~boot_reg & ~en_pull;
    assign pg_fault = ~s2_reg[rsfs_pkg::F_PGWIN]
                    | (ss_done & s2_reg[rsfs_pkg::F_UV]
                       & ~s2_reg[rsfs_pkg::F_OV113] & ~s2_reg[rsfs_pkg::F_OC]
                       & ~ot_reg & s2_reg[rsfs_pkg::F_LOCK]);

    // sequencer state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= rsfs_pkg::ST_OFF;
            dly_reg <= '0;
        end else if (!por_ok) begin
            st_reg <= rsfs_pkg::ST_OFF;
            dly_reg <= '0;
        end else begin
            case (st_reg)
                rsfs_pkg::ST_OFF: begin
                    dly_reg <= '0;
                    if (ready) begin
                        st_reg <= rsfs_pkg::ST_WAIT;
                    end
                end
                rsfs_pkg::ST_WAIT: begin
                    if (!ready) begin
                        st_reg <= rsfs_pkg::ST_OFF;
                    end else if (dly_reg == rsfs_pkg::DLY_W'(rsfs_pkg::START_DELAY - 1)) begin
                        if (s2_reg[rsfs_pkg::F_OV120]) begin
                            st_reg <= rsfs_pkg::ST_LATCH;
                        end else begin
                            st_reg <= rsfs_pkg::ST_SOFT;
                        end
                    end else begin
                        dly_reg <= dly_reg + 1'b1;
                    end
                end
                rsfs_pkg::ST_SOFT, rsfs_pkg::ST_RUN: begin
                    if (s2_reg[rsfs_pkg::F_OV120]) begin
                        st_reg <= rsfs_pkg::ST_LATCH;
                    end else if (!ready) begin
                        st_reg <= rsfs_pkg::ST_OFF;
                    end else if (ss_done) begin
                        st_reg <= rsfs_pkg::ST_RUN;
                    end
                end
                rsfs_pkg::ST_LATCH: begin
                    st_reg <= rsfs_pkg::ST_LATCH;
                end
                default: begin
                    st_reg <= rsfs_pkg::ST_OFF;
                end
            endcase
        end
    end

    // soft-start ramp counter
    always_ff @(posedge aclk) begin
        if (!aresetn || !run_st) begin
            ss_reg <= '0;
        end else if (s2_reg[rsfs_pkg::F_PH] && !ss_done) begin
            ss_reg <= ss_reg + 1'b1;
        end
    end

    // pre-charge arming and bootstrap hold
    always_ff @(posedge aclk) begin
        if (!aresetn || !run_st) begin
            armed_reg <= 1'b0;
            boot_reg <= 1'b0;
        end else if (!armed_reg) begin
            if (s2_reg[rsfs_pkg::F_MOD] && !s2_reg[rsfs_pkg::F_ABOVE]) begin
                armed_reg <= 1'b1;
                boot_reg <= 1'b1;
            end
        end else if (s2_reg[rsfs_pkg::F_PH]) begin
            boot_reg <= 1'b0;
        end
    end

    // overvoltage and temperature protection
    always_ff @(posedge aclk) begin
        if (!aresetn || !por_ok) begin
            ovl_ls_reg <= 1'b0;
            nl_ls_reg <= 1'b0;
            pre_hold_reg <= 1'b0;
            ot_reg <= 1'b0;
        end else begin
            if (run_st && s2_reg[rsfs_pkg::F_OV120]) begin
                ovl_ls_reg <= 1'b1;
            end else if (s2_reg[rsfs_pkg::F_B87]) begin
                ovl_ls_reg <= 1'b0;
            end
            if (!s2_reg[rsfs_pkg::F_EN] && s2_reg[rsfs_pkg::F_OV113]) begin
                nl_ls_reg <= 1'b1;
            end else if (s2_reg[rsfs_pkg::F_B87]) begin
                nl_ls_reg <= 1'b0;
            end
            if ((st_reg == rsfs_pkg::ST_OFF || st_reg == rsfs_pkg::ST_WAIT)
                && s2_reg[rsfs_pkg::F_OV113] && !s2_reg[rsfs_pkg::F_OV120]) begin
                pre_hold_reg <= 1'b1;
            end else if (s2_reg[rsfs_pkg::F_B87]) begin
                pre_hold_reg <= 1'b0;
            end
            if (s2_reg[rsfs_pkg::F_HOT]) begin
                ot_reg <= 1'b1;
            end else if (s2_reg[rsfs_pkg::F_COOL]) begin
                ot_reg <= 1'b0;
            end
        end
    end

    // gate drives and enable line
    always_ff @(posedge aclk) begin
        if (!aresetn || !por_ok) begin
            high_side_gate_drive <= 1'b0;
            low_side_gate_drive <= 1'b0;
            en_oe_n <= 1'b1;
            en_sink_on <= 1'b1;
        end else begin
            high_side_gate_drive <= drive_ok & s2_reg[rsfs_pkg::F_PWM];
            low_side_gate_drive <= ovl_ls_reg | nl_ls_reg
                                 | (drive_ok & ~s2_reg[rsfs_pkg::F_PWM]);
            en_oe_n <= ~en_pull;
            en_sink_on <= ~run_st;
        end
    end

    assign en_o = 1'b0;
    assign soft_start_ref = ss_reg;

    // power-good filter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flt_reg <= '0;
            power_good_output <= 1'b0;
        end else begin
            if (!pg_fault) begin
                flt_reg <= '0;
            end else if (flt_reg != rsfs_pkg::FLT_W'(rsfs_pkg::PG_FILT - 1)) begin
                flt_reg <= flt_reg + 1'b1;
            end
            power_good_output <= st_reg == rsfs_pkg::ST_RUN && ready
                && !(pg_fault && flt_reg == rsfs_pkg::FLT_W'(rsfs_pkg::PG_FILT - 1));
        end
    end

    // axi4-lite write channel
    assign s_axi_awready = ~aw_got_reg & ~s_axi_bvalid;
    assign s_axi_wready = ~w_got_reg & ~s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= rsfs_pkg::RESP_OK;
            sw_en_reg <= rsfs_pkg::CTRL_EN_RST;
            phases_reg <= rsfs_pkg::PHASES_RST;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (aw_got_reg && w_got_reg) begin
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= known(awaddr_reg) ? rsfs_pkg::RESP_OK : rsfs_pkg::RESP_SLVERR;
                if (awaddr_reg == rsfs_pkg::A_CTRL && wstrb_reg[0]) begin
                    sw_en_reg <= wdata_reg[rsfs_pkg::CTRL_EN_BIT];
                end
                if (awaddr_reg == rsfs_pkg::A_PHASES && wstrb_reg[0]) begin
                    if (wdata_reg[7:0] > 8'(rsfs_pkg::MAX_PHASES)) begin
                        phases_reg <= rsfs_pkg::PH_W'(rsfs_pkg::MAX_PHASES);
                    end else if (wdata_reg[7:0] != 8'h0) begin
                        phases_reg <= wdata_reg[rsfs_pkg::PH_W-1:0];
                    end
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // axi4-lite read channel
    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= rsfs_pkg::RESP_OK;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= known(s_axi_araddr) ? rsfs_pkg::RESP_OK : rsfs_pkg::RESP_SLVERR;
            case (s_axi_araddr)
                rsfs_pkg::A_CTRL: s_axi_rdata <= {31'h0, sw_en_reg};
                rsfs_pkg::A_STATUS: s_axi_rdata <= {23'h0, pre_hold_reg, ot_reg,
                    en_oe_n, power_good_output, ss_done, armed_reg, st_reg};
                rsfs_pkg::A_SSCNT: s_axi_rdata <= 32'(ss_reg);
                rsfs_pkg::A_PHASES: s_axi_rdata <= {29'h0, phases_reg};
                default: s_axi_rdata <= 32'h0;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // checks
    sequence s_wait_end;
        st_reg == rsfs_pkg::ST_WAIT ##1 st_reg == rsfs_pkg::ST_SOFT;
    endsequence
    sequence s_flt3;
        pg_fault [*3];
    endsequence
    sequence s_supply_loss;
        $fell(por_ok);
    endsequence

    AST_START_DELAY: assert property (@(posedge aclk) disable iff (!aresetn)
        s_wait_end |-> $past(dly_reg) == rsfs_pkg::DLY_W'(rsfs_pkg::START_DELAY - 1))
        else $error("soft-start began before the start delay");
    AST_SINK_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
        (run_st && por_ok) ##1 (run_st && por_ok) |-> !en_sink_on)
        else $error("enable sink still on while enabled");
    AST_SUPPLY_LOSS: assert property (@(posedge aclk) disable iff (!aresetn)
        s_supply_loss |-> ##[1:GOFF] (!high_side_gate_drive && !low_side_gate_drive && ss_reg == '0))
        else $error("gates not off after supply loss");
    AST_FAULT_PULL: assert property (@(posedge aclk) disable iff (!aresetn)
        (por_ok && (ot_reg || st_reg == rsfs_pkg::ST_LATCH)) ##1 por_ok |-> !en_oe_n)
        else $error("enable line not pulled on fault");
    AST_NO_EARLY_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
        !armed_reg |=> !high_side_gate_drive)
        else $error("high side driven before first modulator pulse");
    AST_BOOT_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
        (boot_reg && !ovl_ls_reg && !nl_ls_reg) |=> !low_side_gate_drive)
        else $error("low side not held during bootstrap cycle");
    AST_PG_AFTER_SS: assert property (@(posedge aclk) disable iff (!aresetn)
        power_good_output |-> $past(st_reg) == rsfs_pkg::ST_RUN)
        else $error("power-good before soft-start done");
    AST_PG_FILTER: assert property (@(posedge aclk) disable iff (!aresetn)
        s_flt3 |=> !power_good_output)
        else $error("power-good not dropped after three faulty cycles");
    AST_PG_GLITCH: assert property (@(posedge aclk) disable iff (!aresetn)
        (power_good_output && st_reg == rsfs_pkg::ST_RUN && ready && flt_reg == '0) |=> power_good_output)
        else $error("power-good dropped on a short excursion");
    AST_OV_LATCH: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_reg == rsfs_pkg::ST_LATCH && por_ok) |=> (!power_good_output && !high_side_gate_drive))
        else $error("latched state drives power-good or high side");
    AST_NL_OV: assert property (@(posedge aclk) disable iff (!aresetn)
        (por_ok && !s2_reg[rsfs_pkg::F_EN] && s2_reg[rsfs_pkg::F_OV113]) |=> nl_ls_reg ##1 (low_side_gate_drive || !por_ok))
        else $error("low side not turned on above 113 percent");
    AST_OT_HYST: assert property (@(posedge aclk) disable iff (!aresetn)
        (ot_reg && por_ok && !s2_reg[rsfs_pkg::F_COOL]) |=> ot_reg)
        else $error("over-temperature released above release point");
endmodule
`default_nettype wire

// [sim/rsfs_peer.sv]
// peer regulator module on the shared open-drain enable line
`default_nettype none
module rsfs_peer #(
    parameter int PHASES = 2
) (
    // clock
    input wire logic aclk,
    // bench control
    input wire logic supplies_ok,
    input wire logic fault_req,
    // shared enable line
    output logic en_o,
    output logic en_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    assign en_o = 1'b0;
    // hold the line low until supplies settle, and on its own fault
    always_ff @(posedge aclk) begin
        en_oe_n <= supplies_ok && !fault_req;
    end
    initial begin
        if (PHASES > rsfs_pkg::MAX_PHASES) begin
            $error("too many phases on share bus");
        end
    end
endmodule
`default_nettype wire

// [sim/regulator_startup_fault_sequencer_tb.sv]
// self-checking bench for the start-up and fault sequencer
`default_nettype none
module regulator_startup_fault_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 0;
    logic aresetn = 0;
    logic [3:0] awaddr = 0, araddr = 0, wstrb = 0;
    logic [31:0] wdata = 0, rdata;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic vcc = 0, gds = 0, lock = 0, ovl = 0, ov = 0, brel = 1, abv = 0, pgw = 1;
    logic uv = 0, oc = 0, hot = 0, cool = 1, modp = 0, pwm = 0, php = 0, sup_ok = 0, peer_flt = 0;
    logic en_o, en_oe_n, sink, hs, ls, pg, peer_o, peer_oe_n, en_line;
    logic [9:0] ss;
    logic [1:0] bq[$];
    logic [33:0] rq[$];
    int fail_count = 0;
    int n_checks = 0;
    integer seed = 32'h1f37bae6;
    always #5 aclk = ~aclk;
    // pulled-up open-drain line
    assign en_line = !(en_oe_n === 1'b0 || peer_oe_n === 1'b0);
    rsfs_sequencer #(.SS_W(10), .SS_TOP(7)) dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .vcc_por_ok(vcc), .gate_drive_supply_por_ok(gds), .en_pin_level(en_line), .pll_locked(lock),
        .ov_latch_trip(ovl), .ov_trip(ov), .below_release(brel), .above_target(abv),
        .pg_window_ok(pgw), .uv_trip(uv), .oc_fault(oc), .ot_hot(hot), .ot_cool(cool),
        .modulator_pulse(modp), .pwm_in(pwm), .phase_pulse(php),
        .en_o(en_o), .en_oe_n(en_oe_n), .en_sink_on(sink),
        .high_side_gate_drive(hs), .low_side_gate_drive(ls),
        .power_good_output(pg), .soft_start_ref(ss)
    );
    rsfs_peer #(.PHASES(2)) peer (
        .aclk(aclk), .supplies_ok(sup_ok), .fault_req(peer_flt), .en_o(peer_o), .en_oe_n(peer_oe_n)
    );
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic tend(input string s);
        $display("test %s done, mismatches %0d", s, fail_count);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic pulse_ph();
        php <= 1'b1;
        cyc(1);
        php <= 1'b0;
        cyc(4);
    endtask
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        int i;
        bq.push_back(r);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                bready <= 1'b0;
                break;
            end
        end
        if (i == 50) begin
            fail_count++;
            test_done();
        end
        @(posedge aclk);
    endtask
    task automatic axi_rd(input logic [3:0] a, input logic [33:0] e);
        int i;
        rq.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                rready <= 1'b0;
                break;
            end
        end
        if (i == 50) begin
            fail_count++;
            test_done();
        end
        @(posedge aclk);
    endtask
    // response monitor compares against the oldest note
    always @(posedge aclk) begin
        if (bvalid && bready) begin
            chk(bresp, bq.pop_front());
        end
        if (rvalid && rready) begin
            chk({rresp, rdata}, rq.pop_front());
        end
    end
    initial begin
        logic [31:0] d;
        cyc(12);
        aresetn <= 1'b1;
        cyc(1);
        chk({en_o, pg, hs, ls, en_oe_n, sink, ss}, {6'h03, 10'h0});
        axi_rd(4'h0, {2'h0, 32'h1});
        axi_rd(4'h4, {2'h0, 32'h40});
        axi_rd(4'h2, {2'h2, 32'h0});
        axi_wr(4'h2, 32'h1, 2'h2);
        d = $unsigned($random(seed)) % 6 + 1;
        axi_wr(4'hc, d, 2'h0);
        axi_rd(4'hc, {2'h0, d});
        axi_wr(4'hc, 32'h7, 2'h0);
        axi_wr(4'hc, 32'h0, 2'h0);
        axi_rd(4'hc, {2'h0, 32'h6});
        tend("registers");
        vcc <= 1'b1;
        gds <= 1'b1;
        lock <= 1'b1;
        sup_ok <= 1'b1;
        pwm <= 1'b1;
        cyc(360);
        chk({sink, ss}, {1'b1, 10'h0});
        cyc(29);
        chk(sink, 1'b1);
        cyc(1);
        chk(sink, 1'b0);
        cyc(10);
        modp <= 1'b1;
        cyc(1);
        modp <= 1'b0;
        cyc(5);
        chk({hs, ls}, 2'h0);
        for (int k = 1; k <= 7; k++) begin
            pulse_ph();
            chk(ss, k);
            if (k == 3) chk(pg, 1'b0);
        end
        cyc(5);
        chk({pg, sink, hs, ls}, 4'ha);
        tend("start-up");
        pgw <= 1'b0;
        cyc(2);
        pgw <= 1'b1;
        cyc(6);
        chk(pg, 1'b1);
        pgw <= 1'b0;
        cyc(3);
        pgw <= 1'b1;
        cyc(3);
        chk(pg, 1'b0);
        cyc(3);
        chk(pg, 1'b1);
        uv <= 1'b1;
        cyc(6);
        chk(pg, 1'b0);
        uv <= 1'b0;
        cyc(6);
        chk(pg, 1'b1);
        tend("power-good filter");
        peer_flt <= 1'b1;
        cyc(6);
        chk({pg, sink, hs, ls}, 4'h4);
        ov <= 1'b1;
        brel <= 1'b0;
        cyc(6);
        chk({ls, en_oe_n}, 2'h2);
        ov <= 1'b0;
        brel <= 1'b1;
        cyc(6);
        chk(ls, 1'b0);
        peer_flt <= 1'b0;
        hot <= 1'b1;
        cool <= 1'b0;
        cyc(6);
        chk(en_oe_n, 1'b0);
        hot <= 1'b0;
        cyc(6);
        chk(en_oe_n, 1'b0);
        cool <= 1'b1;
        cyc(6);
        chk(en_oe_n, 1'b1);
        oc <= 1'b1;
        cyc(6);
        chk(en_oe_n, 1'b0);
        oc <= 1'b0;
        cyc(6);
        chk(en_oe_n, 1'b1);
        tend("faults while off");
        cyc(400);
        abv <= 1'b1;
        modp <= 1'b1;
        cyc(1);
        abv <= 1'b0;
        modp <= 1'b0;
        cyc(3);
        axi_rd(4'h4, {2'h0, 32'h42});
        modp <= 1'b1;
        cyc(1);
        modp <= 1'b0;
        pulse_ph();
        pulse_ph();
        chk({hs, ss}, {1'b1, 10'h2});
        vcc <= 1'b0;
        cyc(5);
        chk({hs, ls, ss}, 12'h0);
        vcc <= 1'b1;
        cyc(410);
        ovl <= 1'b1;
        ov <= 1'b1;
        brel <= 1'b0;
        cyc(6);
        chk({en_oe_n, pg, hs, ls}, 4'h1);
        ovl <= 1'b0;
        ov <= 1'b0;
        brel <= 1'b1;
        cyc(20);
        chk({en_oe_n, ls}, 2'h0);
        vcc <= 1'b0;
        cyc(8);
        chk(en_oe_n, 1'b1);
        tend("overvoltage latch");
        ovl <= 1'b1;
        ov <= 1'b1;
        brel <= 1'b0;
        vcc <= 1'b1;
        cyc(400);
        chk({en_oe_n, hs, ls, sink}, 4'h3);
        axi_rd(4'h4, {2'h0, 32'h4});
        ovl <= 1'b0;
        ov <= 1'b0;
        brel <= 1'b1;
        vcc <= 1'b0;
        axi_wr(4'h0, 32'h0, 2'h0);
        vcc <= 1'b1;
        cyc(400);
        axi_rd(4'h4, {2'h0, 32'h40});
        axi_wr(4'h0, 32'h1, 2'h0);
        cyc(400);
        axi_rd(4'h4, {2'h0, 32'h42});
        tend("pre-charge and control");
        test_done();
    end
endmodule
`default_nettype wire
